// *** inc/hps_pkg.sv ***
// constants, types and state records for the host port select and power control block
// Functional notes
// - pulled-up select input defaults to usb
// - select driven low enables sdio port
// - sdio works in one and four line modes
// - four line interrupt only in special window
// - card information served from on-chip table
// - mailbox register and interrupt toward host
// - host reaches shared memory through base window
// - usb runs high or full speed
// - usb suspend, host resume, remote wake
// - link power sleep left by either resume
// - power-on reset restores defaults and boots
// - host soft reset restores defaults (not the card table index) and boots
// - power-down pin rising edge resets and boots
// - power-down pin low holds lowest leakage
// - two antenna outputs complementary outside core reset, both low in reset
// - two addresses, last bit zero then one
// - calibration runs at every power up
// - power save uses host wake and wake input
// - single line mode interrupts on data line one
// - dedicated host wake output
// - wake input active high, programmable pull
package hps_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] STATUS_OFF  = 8'h04;
  localparam logic [7:0] ADDR1_LO    = 8'h08;
  localparam logic [7:0] ADDR_HI_OFF = 8'h0C;
  localparam logic [7:0] ADDR2_LO    = 8'h10;
  localparam logic [7:0] MAILBOX_OFF = 8'h14;
  localparam logic [7:0] CIS_IX_OFF  = 8'h18;
  localparam logic [7:0] CIS_DAT_OFF = 8'h1C;
  localparam logic [7:0] WINDOW_OFF  = 8'h20;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int C_SOFT   = 0;
  localparam int C_ANT    = 1;
  localparam int C_WIDE   = 2;
  localparam int C_HWAKE  = 3;
  localparam int C_RWAKE  = 4;
  localparam int C_PULLUP = 5;
  localparam int C_RAISE  = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // ****************************************
  // bus answers and misc widths
  // ****************************************
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [47:0] ADDR_LSB    = 48'h0000_0000_0001;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ       = 100;
  localparam int CORE_RST_NS   = 200;
  localparam int CORE_RST_CYC  = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] RST_CNT_LAST = 5'(CORE_RST_CYC - 1);
  localparam logic [4:0] RST_CNT_ZERO = 5'h00;

  // ****************************************
  // card information table
  // ****************************************
  localparam int CIS_DEPTH = 16;
  localparam logic [7:0] CIS_INIT [CIS_DEPTH] = '{
    8'h21, 8'h02, 8'h0C, 8'h00, 8'h22, 8'h04, 8'h00, 8'h00,
    8'h08, 8'h32, 8'h15, 8'h02, 8'h01, 8'h00, 8'hFF, 8'h00};

  // ****************************************
  // sequencer states and records
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_PDOWN = 3'b000,
    SEQ_RESET = 3'b001,
    SEQ_BOOT  = 3'b010,
    SEQ_CAL   = 3'b011,
    SEQ_RUN   = 3'b100
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic [4:0]    cnt;
    logic          pd_prev;
    logic          core_rst;
    logic          boot;
    logic          cal_req;
  } seq_reg_type;

  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bus_reg_type;

  typedef struct packed {
    bus_reg_type bus;
    logic [6:0]  ctrl;
    logic [7:0]  mailbox;
    logic        irq_pend;
    logic [3:0]  cis_ix;
    logic [31:0] window;
    logic        rwake;
    logic        usb_en;
    logic        sdio_en;
    logic        ant;
    logic        ant_inv;
    logic        hwake;
    logic        d1_out;
    logic        d1_oe;
  } top_reg_type;

endpackage : hps_pkg

// *** src/hps_seq.sv ***
// reset, boot and calibration sequencer
`timescale 1ns/1ps
module hps_seq
  import hps_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // reset sources
  input  wire logic pd_n_i,
  input  wire logic soft_i,
  // calibration handshake
  input  wire logic cal_done_i,
  // sequence outputs
  output logic      core_rst_o,
  output logic      boot_o,
  output logic      cal_req_o,
  output logic      pdown_o
);

  seq_reg_type s_q, s_d;  // whole sequencer state

  // next state: power-down wins, then pin edge or soft reset
  always_comb begin
    s_d          = s_q;
    s_d.pd_prev  = pd_n_i;
    s_d.boot     = 1'b0;
    unique case (s_q.st)
      SEQ_PDOWN: begin
        s_d.core_rst = 1'b1;
        if (pd_n_i && !s_q.pd_prev) begin
          s_d.st  = SEQ_RESET;
          s_d.cnt = RST_CNT_ZERO;
        end
      end
      SEQ_RESET: begin
        s_d.core_rst = 1'b1;
        s_d.cnt      = s_q.cnt + 5'h01;
        if (s_q.cnt == RST_CNT_LAST) begin
          s_d.st   = SEQ_BOOT;
          s_d.boot = 1'b1;
        end
      end
      SEQ_BOOT: begin
        s_d.core_rst = 1'b0;
        s_d.cal_req  = 1'b1;
        s_d.st       = SEQ_CAL;
      end
      SEQ_CAL: begin
        if (cal_done_i) begin
          s_d.cal_req = 1'b0;
          s_d.st      = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        s_d.core_rst = 1'b0;
      end
      default: s_d.st = SEQ_PDOWN;
    endcase
    // host soft reset restarts the whole boot
    if (soft_i && s_q.st != SEQ_PDOWN) begin
      s_d.st       = SEQ_RESET;
      s_d.cnt      = RST_CNT_ZERO;
      s_d.core_rst = 1'b1;
      s_d.cal_req  = 1'b0;
    end
    // low pin forces lowest leakage state
    if (!pd_n_i) begin
      s_d.st       = SEQ_PDOWN;
      s_d.core_rst = 1'b1;
      s_d.cal_req  = 1'b0;
    end
  end

  // power-on reset lands in power-down until the pin rises
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: SEQ_PDOWN, cnt: RST_CNT_ZERO, pd_prev: 1'b0,
               core_rst: 1'b1, boot: 1'b0, cal_req: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign core_rst_o = s_q.core_rst;
  assign boot_o     = s_q.boot;
  assign cal_req_o  = s_q.cal_req;
  assign pdown_o    = (s_q.st == SEQ_PDOWN);

  // ****************************************
  // checks
  // ****************************************
  // twenty quiet reset cycles, split so no repetition unrolls past eight
  chk_pin_rise_boot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == SEQ_PDOWN && $rose(pd_n_i)) ##1 (pd_n_i && !soft_i) [*8]
      ##1 (pd_n_i && !soft_i) [*8] ##1 (pd_n_i && !soft_i) [*4]
      |-> ##1 boot_o)
    else $error("pin rise did not boot on time");
  chk_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (soft_i && pd_n_i && s_q.st != SEQ_PDOWN) |=> core_rst_o && s_q.st == SEQ_RESET)
    else $error("soft reset ignored");
  chk_pd_low_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pd_n_i |=> pdown_o && core_rst_o && !cal_req_o)
    else $error("power-down not held");
  chk_cal_after_boot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (boot_o && pd_n_i && !soft_i) |=> cal_req_o)
    else $error("no calibration after boot");
  cov_boot: cover property (@(posedge clk_i) disable iff (!rst_n_i) boot_o);
  cov_cal_done: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cal_req_o ##1 !cal_req_o && s_q.st == SEQ_RUN);

endmodule : hps_seq

// *** src/hps_top.sv ***
// host port select, power mode and register slave top level
`timescale 1ns/1ps
module hps_top
  import hps_pkg::*;
#(
  parameter logic [47:0] FIRST_ADDR = 48'h0200_0000_1000  // arbitrary value
)(
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  // axi4-lite write address and data
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  // axi4-lite write response
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  output logic [1:0]       BRESP_O,
  // axi4-lite read
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  input  wire logic [7:0]  ARADDR_I,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  // board pins
  input  wire logic        PORT_SEL_N_I,
  input  wire logic        POWERDOWN_PIN_N_I,
  input  wire logic        WAKE_UP_I,
  output logic             WAKE_PULL_UP_O,
  output logic             HOST_WAKE_OUT_O,
  output logic             ANTENNA_CHOICE_O,
  output logic             ANTENNA_CHOICE_INV_O,
  // sdio core side
  input  wire logic        SD_IRQ_WINDOW_I,
  input  wire logic        SD_IRQ_ACK_I,
  output logic             SDIO_EN_O,
  output logic             SDIO_WIDE_O,
  output logic [31:0]      SHARED_BASE_O,
  output logic             SD_DATA_LINE_ONE_O,
  output logic             SD_DATA_LINE_ONE_OE_O,
  // usb core side
  input  wire logic        USB_HIGH_SPEED_I,
  input  wire logic        USB_SUSPEND_I,
  input  wire logic        USB_L1_I,
  output logic             USB_EN_O,
  output logic             USB_REMOTE_WAKE_O,
  // processor and radio side
  input  wire logic        CAL_DONE_I,
  output logic             CORE_RST_O,
  output logic             BOOT_O,
  output logic             CAL_REQ_O
);

  // ****************************************
  // declarations
  // ****************************************
  top_reg_type r_q, r_d;          // whole block state
  logic        core_rst;          // sequencer holds core in reset
  logic        boot;              // one-cycle boot start
  logic        cal_req;           // calibration running
  logic        pdown;             // lowest leakage state
  logic        soft_pulse;        // host soft reset write
  logic        wr_fire;           // both write halves present
  logic [47:0] addr_one;          // first address, used for wireless
  logic [47:0] addr_two;          // second address, free for use
  logic [7:0]  cis_mem [CIS_DEPTH];  // on-chip card information

  // table fixed at build time
  assign cis_mem = CIS_INIT;

  // second address is the first with its last bit set
  function automatic logic [47:0] addr_of(input logic second);
    addr_of = second ? (FIRST_ADDR | ADDR_LSB) : (FIRST_ADDR & ~ADDR_LSB);
  endfunction

  // whole words held apart so the decode can slice them
  assign addr_one = addr_of(1'b0);
  assign addr_two = addr_of(1'b1);

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // any known offset, for the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFF) || (a == STATUS_OFF) || (a == ADDR1_LO) ||
             (a == ADDR_HI_OFF) || (a == ADDR2_LO) || (a == MAILBOX_OFF) ||
             (a == CIS_IX_OFF) || (a == CIS_DAT_OFF) || (a == WINDOW_OFF);
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  hps_seq u_seq (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RST_N_I),
    .pd_n_i     (POWERDOWN_PIN_N_I),
    .soft_i     (soft_pulse),
    .cal_done_i (CAL_DONE_I),
    .core_rst_o (core_rst),
    .boot_o     (boot),
    .cal_req_o  (cal_req),
    .pdown_o    (pdown)
  );

  assign wr_fire    = r_q.bus.aw_ok && r_q.bus.w_ok && !r_q.bus.bvalid;
  assign soft_pulse = wr_fire && r_q.bus.aw_addr == CTRL_OFF &&
                      r_q.bus.w_strb[0] && r_q.bus.w_data[C_SOFT];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    rd  = ZERO_WORD;
    wv  = ZERO_WORD;
    r_d = r_q;
    // address and data taken in either order
    if (AWVALID_I && !r_q.bus.aw_ok) begin
      r_d.bus.aw_ok   = 1'b1;
      r_d.bus.aw_addr = AWADDR_I;
    end
    if (WVALID_I && !r_q.bus.w_ok) begin
      r_d.bus.w_ok   = 1'b1;
      r_d.bus.w_data = WDATA_I;
      r_d.bus.w_strb = WSTRB_I;
    end
    // register write once both halves are held
    if (wr_fire) begin
      r_d.bus.bvalid = 1'b1;
      r_d.bus.bresp  = mapped(r_q.bus.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      wv = merge(ZERO_WORD, r_q.bus.w_data, r_q.bus.w_strb);
      unique case (r_q.bus.aw_addr)
        CTRL_OFF: begin
          if (r_q.bus.w_strb[0]) begin
            r_d.ctrl = wv[6:0];
            r_d.ctrl[C_SOFT]  = 1'b0;  // self clearing
            r_d.ctrl[C_RAISE] = 1'b0;
            if (wv[C_RAISE]) r_d.irq_pend = 1'b1;
          end
        end
        MAILBOX_OFF: begin
          if (r_q.bus.w_strb[0]) r_d.mailbox = wv[7:0];
        end
        CIS_IX_OFF: begin
          if (r_q.bus.w_strb[0]) r_d.cis_ix = wv[3:0];
        end
        WINDOW_OFF: r_d.window = merge(r_q.window, r_q.bus.w_data, r_q.bus.w_strb);
        default: ;  // read-only or unmapped: no store
      endcase
    end
    // response retires the write
    if (r_q.bus.bvalid && BREADY_I) begin
      r_d.bus.bvalid = 1'b0;
      r_d.bus.aw_ok  = 1'b0;
      r_d.bus.w_ok   = 1'b0;
    end
    // read decode
    unique case (ARADDR_I)
      CTRL_OFF:    rd = {25'h000_0000, r_q.ctrl};
      STATUS_OFF:  rd = {22'h00_0000, USB_HIGH_SPEED_I, r_q.irq_pend, WAKE_UP_I,
                         USB_L1_I, USB_SUSPEND_I, !cal_req && !core_rst, cal_req,
                         core_rst, pdown, !PORT_SEL_N_I};
      ADDR1_LO:    rd = addr_one[31:0];
      ADDR_HI_OFF: rd = {16'h0000, addr_one[47:32]};
      ADDR2_LO:    rd = addr_two[31:0];
      MAILBOX_OFF: rd = {24'h00_0000, r_q.mailbox};
      CIS_IX_OFF:  rd = {28'h000_0000, r_q.cis_ix};
      CIS_DAT_OFF: rd = {24'h00_0000, cis_mem[r_q.cis_ix]};
      WINDOW_OFF:  rd = r_q.window;
      default:     rd = ZERO_WORD;
    endcase
    if (ARVALID_I && !r_q.bus.rvalid) begin
      r_d.bus.rvalid = 1'b1;
      r_d.bus.rdata  = rd;
      r_d.bus.rresp  = mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_q.bus.rvalid && RREADY_I) begin
      r_d.bus.rvalid = 1'b0;
    end
    // host acknowledge clears, a same-cycle raise wins
    if (SD_IRQ_ACK_I && !(wr_fire && r_q.bus.aw_addr == CTRL_OFF && wv[C_RAISE])) begin
      r_d.irq_pend = 1'b0;
    end
    // remote wake only while suspended or in l1, dropped on resume
    if (r_q.ctrl[C_RWAKE] && (USB_SUSPEND_I || USB_L1_I)) begin
      r_d.rwake = 1'b1;
    end
    if (!USB_SUSPEND_I && !USB_L1_I) begin
      r_d.rwake = 1'b0;
      r_d.ctrl[C_RWAKE] = 1'b0;
    end
    // port choice: high select (pulled up) means usb
    r_d.usb_en  = PORT_SEL_N_I && !core_rst;
    r_d.sdio_en = !PORT_SEL_N_I && !core_rst;
    // antenna pair, each other's inverse except both low in core reset
    r_d.ant     = r_d.ctrl[C_ANT];
    r_d.ant_inv = !r_d.ctrl[C_ANT];
    r_d.hwake   = r_d.ctrl[C_HWAKE];
    // interrupt on line one: always in 1-bit, windowed in 4-bit
    r_d.d1_oe  = r_d.sdio_en && r_d.irq_pend &&
                 (!r_d.ctrl[C_WIDE] || SD_IRQ_WINDOW_I);
    r_d.d1_out = 1'b0;  // interrupt is a low level on the line
    // soft or pin reset returns software state except the card table index to defaults
    if (core_rst) begin
      r_d.ctrl     = CTRL_RESET;
      r_d.mailbox  = 8'h00;
      r_d.irq_pend = 1'b0;
      r_d.rwake    = 1'b0;
      r_d.window   = ZERO_WORD;
      r_d.usb_en   = 1'b0;
      r_d.sdio_en  = 1'b0;
      r_d.ant      = 1'b0;
      r_d.ant_inv  = 1'b0;
      r_d.hwake    = 1'b0;
      r_d.d1_oe    = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // outputs straight from flops
  // ****************************************
  assign AWREADY_O             = !r_q.bus.aw_ok;
  assign WREADY_O              = !r_q.bus.w_ok;
  assign BVALID_O              = r_q.bus.bvalid;
  assign BRESP_O               = r_q.bus.bresp;
  assign ARREADY_O             = !r_q.bus.rvalid;
  assign RVALID_O              = r_q.bus.rvalid;
  assign RDATA_O               = r_q.bus.rdata;
  assign RRESP_O               = r_q.bus.rresp;
  assign WAKE_PULL_UP_O        = r_q.ctrl[C_PULLUP];
  assign HOST_WAKE_OUT_O       = r_q.hwake;
  assign ANTENNA_CHOICE_O      = r_q.ant;
  assign ANTENNA_CHOICE_INV_O  = r_q.ant_inv;
  assign SDIO_EN_O             = r_q.sdio_en;
  assign SDIO_WIDE_O           = r_q.ctrl[C_WIDE];
  assign SHARED_BASE_O         = r_q.window;
  assign SD_DATA_LINE_ONE_O    = r_q.d1_out;
  assign SD_DATA_LINE_ONE_OE_O = r_q.d1_oe;
  assign USB_EN_O              = r_q.usb_en;
  assign USB_REMOTE_WAKE_O     = r_q.rwake;
  assign CORE_RST_O            = core_rst;
  assign BOOT_O                = boot;
  assign CAL_REQ_O             = cal_req;

  // ****************************************
  // checks
  // ****************************************
  chk_usb_default: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (PORT_SEL_N_I && !core_rst) |=> USB_EN_O && !SDIO_EN_O)
    else $error("usb not chosen with select high");
  chk_sdio_select: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (!PORT_SEL_N_I && !core_rst) |=> SDIO_EN_O && !USB_EN_O)
    else $error("sdio not chosen with select low");
  chk_antenna_pair: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !CORE_RST_O ##1 !CORE_RST_O |-> ANTENNA_CHOICE_O != ANTENNA_CHOICE_INV_O)
    else $error("antenna outputs not complementary");
  chk_pd_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !POWERDOWN_PIN_N_I ##1 !POWERDOWN_PIN_N_I |=> !USB_EN_O && !SDIO_EN_O &&
      !ANTENNA_CHOICE_O && !ANTENNA_CHOICE_INV_O && !SD_DATA_LINE_ONE_OE_O)
    else $error("port logic active in power-down");
  chk_addr_bits: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (RVALID_O && $past(ARADDR_I) == ADDR2_LO && $rose(RVALID_O)) |->
      RDATA_O[0] && !addr_one[0])
    else $error("address last bits wrong");
  chk_wide_irq: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (SD_DATA_LINE_ONE_OE_O && SDIO_WIDE_O) |-> $past(SD_IRQ_WINDOW_I))
    else $error("wide interrupt outside window");
  chk_narrow_irq: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (r_q.irq_pend && SDIO_EN_O && !PORT_SEL_N_I && !SD_IRQ_ACK_I && !wr_fire &&
     !r_q.ctrl[C_WIDE] && !core_rst) ##1 !core_rst
      |-> SD_DATA_LINE_ONE_OE_O)
    else $error("narrow interrupt not on line one");
  chk_raise_wins: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (soft_pulse == 1'b0 && wr_fire && r_q.bus.aw_addr == CTRL_OFF &&
     r_q.bus.w_strb[0] && r_q.bus.w_data[C_RAISE] && !core_rst) |=> r_q.irq_pend || core_rst)
    else $error("raise lost");
  chk_rwake_drop: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (!USB_SUSPEND_I && !USB_L1_I) |=> !USB_REMOTE_WAKE_O)
    else $error("remote wake held after resume");
  chk_write_answer: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    wr_fire |=> BVALID_O)
    else $error("write not answered");
  cov_sdio_irq: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    SDIO_EN_O && SD_DATA_LINE_ONE_OE_O);
  cov_remote_wake: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    USB_L1_I && USB_REMOTE_WAKE_O);
  cov_slverr: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    RVALID_O && RRESP_O == RESP_SLVERR);

endmodule : hps_top

// *** tb/hps_host_model.sv ***
// behavioural host controller on the far side of the usb and sdio ports
`timescale 1ns/1ps
module hps_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // stimulus from the bench
  input  wire logic sel_usb_i,
  input  wire logic sleep_i,
  input  wire logic slow_i,
  // device pins seen by the host
  input  wire logic irq_line_oe_i,
  // host side answers
  output logic      irq_window_o,
  output logic      irq_ack_o,
  output logic      suspend_o,
  output logic      l1_o,
  output logic      high_speed_o
);
  logic [2:0] phase_q;  // interrupt period phase
  logic [2:0] wait_q;   // cycles the line has been held

  // ****************************************
  // phase and ack timing
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_q <= 3'h0;
      wait_q  <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
      wait_q  <= irq_line_oe_i ? wait_q + 3'h1 : 3'h0;
    end
  end
  // four line mode: interrupt only in this periodic slot
  assign irq_window_o = phase_q[2];
  // host clears the interrupt, quickly or late
  assign irq_ack_o    = (wait_q == (slow_i ? 3'h6 : 3'h1));
  // only the selected port ever sleeps
  assign suspend_o    = sleep_i & sel_usb_i;
  assign l1_o         = sleep_i & sel_usb_i;
  // the slow host also runs the usb port at full speed
  assign high_speed_o = !slow_i;
endmodule // hps_host_model

// *** tb/tb.sv ***
// self-checking bench for the host port select and power block
`timescale 1ns/1ps
module tb;
  import hps_pkg::*;
  logic c = 0, rn = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
  logic sel = 1, pd = 0, wk = 0, cd = 0, slp = 0, slow = 0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0000_0000, d, rdat, base;
  logic [3:0] ws = 4'hf;
  logic [1:0] r, br, rr;
  logic awr, wrd, bv, arr, rv, wpu, hw, ant, anti, sen, swd, d1, d1oe;
  logic uen, urw, crst, boot, creq, win, ack, susp, l1, hs, wp;
  int fail_count = 0, compares = 0;
  // ****************************************
  // clock, design and host model
  // ****************************************
  initial forever #5 c = ~c;
  hps_top #(.FIRST_ADDR(48'h0a00_0000_2000)) DUT (  // arbitrary value
    .SYS_CLK_I(c), .RST_N_I(rn), .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(aw),
    .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(ws), .BVALID_O(bv),
    .BREADY_I(bq), .BRESP_O(br), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ar),
    .RVALID_O(rv), .RREADY_I(rq), .RDATA_O(rdat), .RRESP_O(rr), .PORT_SEL_N_I(sel),
    .POWERDOWN_PIN_N_I(pd), .WAKE_UP_I(wk), .WAKE_PULL_UP_O(wpu), .HOST_WAKE_OUT_O(hw),
    .ANTENNA_CHOICE_O(ant), .ANTENNA_CHOICE_INV_O(anti), .SD_IRQ_WINDOW_I(win),
    .SD_IRQ_ACK_I(ack), .SDIO_EN_O(sen), .SDIO_WIDE_O(swd), .SHARED_BASE_O(base),
    .SD_DATA_LINE_ONE_O(d1), .SD_DATA_LINE_ONE_OE_O(d1oe), .USB_HIGH_SPEED_I(hs),
    .USB_SUSPEND_I(susp), .USB_L1_I(l1), .USB_EN_O(uen), .USB_REMOTE_WAKE_O(urw),
    .CAL_DONE_I(cd), .CORE_RST_O(crst), .BOOT_O(boot), .CAL_REQ_O(creq));
  hps_host_model host (.clk_i(c), .rst_n_i(rn), .sel_usb_i(sel), .sleep_i(slp),
    .slow_i(slow), .irq_line_oe_i(d1oe), .irq_window_o(win), .irq_ack_o(ack),
    .suspend_o(susp), .l1_o(l1), .high_speed_o(hs));
  // window as the design sampled it one edge back
  always @(posedge c) wp <= win;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge c); aw <= a; wd <= v; awv <= 1; wv <= 1; bq <= 1;
    forever begin
      @(posedge c); if (awr) awv <= 0; if (wrd) wv <= 0;
      if (bv) begin r = br; bq <= 0; break; end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge c); ar <= a; arv <= 1; rq <= 1;
    forever begin
      @(posedge c); if (arr) arv <= 0;
      if (rv) begin d = rdat; r = rr; rq <= 0; break; end
    end
  endtask
  // bounded wait for a design output to reach a level
  task automatic till(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) @(posedge c);
  endtask
  task automatic end_of_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_pwr_up;  // pin low then high starts the boot
    @(posedge c); pd <= 0; repeat (2) @(posedge c); pd <= 1;
    till(boot, 1);
    chk(boot, 1);
    @(posedge c); chk({crst, creq}, 2'b01);
    cd <= 1; repeat (3) @(posedge c); chk(creq, 0);
  endtask
  task automatic t_regs;  // addresses, mailbox, window, card table, unmapped
    rd(ADDR1_LO); chk(d, 32'h0000_2000);
    rd(ADDR2_LO); chk(d, 32'h0000_2001);
    rd(ADDR_HI_OFF); chk(d[15:0], 16'h0a00);
    wr(MAILBOX_OFF, 32'h0000_00a5); rd(MAILBOX_OFF); chk(d[7:0], 8'ha5);
    wr(WINDOW_OFF, 32'h1234_5678); chk(base, 32'h1234_5678);
    wr(CIS_IX_OFF, 32'h0000_0002); rd(CIS_DAT_OFF); chk(d[7:0], CIS_INIT[2]);
    wr(8'h40, 32'h0000_0001); chk(r, RESP_SLVERR);
    rd(8'h44); chk(r, RESP_SLVERR);
  endtask
  task automatic t_ant_wake;  // antenna pair, host wake, pull and wake input
    wr(CTRL_OFF, 32'h0000_002a); @(posedge c);
    chk({ant, anti}, 2'b10);
    chk({hw, wpu}, 2'b11);
    wk <= 1; rd(STATUS_OFF); chk(d[7], 1);
    wr(CTRL_OFF, 32'h0000_0000); @(posedge c); chk({ant, anti, wpu}, 3'b010);
  endtask
  task automatic t_usb;  // suspend, remote wake, resume and soft reset
    chk({uen, sen}, 2'b10);
    slp <= 1; repeat (2) @(posedge c);
    wr(CTRL_OFF, 32'h0000_0012); repeat (2) @(posedge c);
    chk(urw, 1);
    rd(STATUS_OFF); chk({d[9], d[6:5]}, 3'b111);
    slp <= 0; repeat (4) @(posedge c); chk(urw, 0);
    wr(CTRL_OFF, 32'h0000_0001); till(boot, 1); chk(boot, 1);
    repeat (4) @(posedge c); rd(CTRL_OFF); chk(d[6:0], CTRL_RESET);
    chk({ant, anti}, 2'b01);
  endtask
  task automatic t_sdio;  // sdio select, line one interrupt in both widths
    sel <= 0; slow <= 1; repeat (3) @(posedge c); chk({uen, sen}, 2'b01);
    wr(CTRL_OFF, 32'h0000_0040); till(d1oe, 1); chk({d1oe, d1}, 2'b10);
    till(d1oe, 0); rd(STATUS_OFF); chk(d[8], 0);
    chk(d[9], 0);
    slow <= 0; wr(CTRL_OFF, 32'h0000_0044); chk(swd, 1);
    till(d1oe, 1); chk(wp, 1);
    till(d1oe, 0); chk(d1oe, 0);
  endtask
  task automatic t_pdown;  // pin low parks everything
    pd <= 0; repeat (3) @(posedge c);
    chk({crst, sen, uen, ant, anti, hw, d1oe}, 7'h40);
    rd(STATUS_OFF); chk(d[1], 1);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge c);
    rn <= 1; repeat (2) @(posedge c);
    chk({crst, uen, ant, anti}, 4'h8);
    t_pwr_up();
    t_regs();
    t_ant_wake();
    t_usb();
    t_sdio();
    t_pdown();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge c);
    fail_count++;
    end_of_test();
  end
endmodule // tb
